// file: hdl/otf_pkg.sv
/*
  Constants for the overheat fault and protection block: register byte
  offsets on the APB slave, field positions, reset values, serial link
  frame layout and timing counts.
  Assumes: used only through otf_pkg::name, never imported.
*/
package otf_pkg;

  // apb register byte offsets
  localparam int          APB_AW          = 8;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_FAULT      = 8'h04;
  localparam logic [7:0]  ADDR_DISP       = 8'h08;
  localparam logic [7:0]  ADDR_INTENS     = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h14;

  // control register fields
  localparam int          CTRL_RUN        = 0;
  localparam int          CTRL_RIPPLE     = 1;
  localparam int          CTRL_PHASE_LSB  = 4;
  localparam int          CTRL_OWN_LSB    = 8;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

  // fault status byte fields
  localparam int          FLT_OPEN        = 0;
  localparam int          FLT_SHORT       = 1;
  localparam int          FLT_HEAT        = 2;
  localparam int          FLT_PART_LSB    = 5;
  localparam int          FLT_SUM         = 7;

  // interrupt status / mask fields
  localparam int          IRQ_HEAT        = 0;
  localparam int          IRQ_LED         = 1;
  localparam int          IRQ_LINK_CLR    = 2;
  localparam int          IRQ_W           = 3;

  // serial link frame: {rw, code[6:0], data[7:0]}, then 8 read bits
  localparam logic [6:0]  LINK_FAULT_CODE = 7'h05;
  localparam logic [4:0]  LINK_HDR_BITS   = 5'h10;
  localparam logic [4:0]  LINK_RD_BITS    = 5'h08;

  // pwm step rate: one step every PWM_DIV clocks
  localparam int          PWM_DIV         = 4;
  localparam logic [1:0]  PWM_DIV_LAST    = 2'(PWM_DIV - 1);

  // serial link receiver states
  typedef enum logic [1:0] {
    LK_IDLE,
    LK_HDR,
    LK_READ
  } otf_link_t;

endpackage : otf_pkg

// file: hdl/otf_sync.sv
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes: each bit is a slow level or a clock sampled for edges; no
  bus-coherence between bits is required.
*/
`timescale 1ns/1ps
`default_nettype none

module otf_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      meta_q <= INIT;
      o_sync <= INIT;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : otf_sync

`default_nettype wire

// file: hdl/otf_top.sv
/*
  Overheat fault latch, shutdown protection, fault status, segment pwm
  and serial status read-back of one matrix driver, with an APB slave.
  Assumes: one 20 MHz clock; reset synchronous active low; overheat
  detector, LED fault comparators and the serial link are asynchronous.
*/
// Local design decisions: the register addresses and register access over APB.
// Notes on behaviour
// RL1: overheat event latches sticky readable flag
// RL2: overheat clears run bit, data kept
// RL3: run set ignored while still hot
// RL4: flag survives cooling and leaving shutdown
// RL5: fault register cleared at reset, on write
// RL6: fault write ignores data, clears all flags
// RL7: reading fault register changes no flag
// RL8: global serial write clears every driver
// RL9: low reset halts, restores control defaults
// RL10: host repeats setup writes after reset
// RL11: host holds reset until supplies settle
// RL12: at most 256 drivers per bus
// RL13: host keeps serial rate within limit
// RL14: serial output drives only read data
// RL15: per-digit intensity sets pwm duty
// RL16: ripple offsets switching phase between drivers
// RL17: open, short, heat flags plus summary
// RL18: LED faults counted only while driving
// RL19: overheat input passes two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none

module otf_top #(
  parameter logic [1:0]  PART_ID = 2'h0 // arbitrary value
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_overheat,
  input  wire logic [15:0] i_led_open,
  input  wire logic [15:0] i_led_short,
  input  wire logic        i_link_sclk,
  input  wire logic        i_link_cs_n,
  input  wire logic        i_link_din,
  output logic             o_link_dout,
  output logic             o_link_dout_oe,
  output logic      [15:0] o_seg,
  output logic             o_shutdown,
  output logic             o_irq
);

  // synchronised inputs
  logic        heat_s;
  logic [31:0] led_s;
  logic [2:0]  link_s;
  logic        sclk_s;
  logic        din_s;
  logic        cs_n_s;

  // RL19 overheat synchroniser
  otf_sync #(.W(1), .INIT(1'b0)) u_sync_heat (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_overheat),
    .o_sync   (heat_s)
  );

  otf_sync #(.W(32), .INIT(32'h0000_0000)) u_sync_led (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  ({i_led_short, i_led_open}),
    .o_sync   (led_s)
  );

  otf_sync #(.W(3), .INIT(3'h1)) u_sync_link (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  ({i_link_sclk, i_link_din, i_link_cs_n}),
    .o_sync   (link_s)
  );

  assign sclk_s = link_s[2];
  assign din_s  = link_s[1];
  assign cs_n_s = link_s[0];

  // registers and state
  logic                    run_q;
  logic                    ripple_q;
  logic [3:0]              phase_q;
  logic [7:0]              own_q;
  logic [15:0]             disp_q;
  logic [7:0]              intens_q;
  logic                    open_q;
  logic                    short_q;
  logic                    heat_flag_q;
  logic [otf_pkg::IRQ_W-1:0] irq_stat_q;
  logic [otf_pkg::IRQ_W-1:0] irq_mask_q;
  logic                    heat_prev_q;
  logic [1:0]              pwm_div_q;
  logic [3:0]              pwm_cnt_q;
  logic [15:0]             seg_q;
  logic                    link_clr_q;
  otf_pkg::otf_link_t      link_st_q;
  logic [4:0]              bit_cnt_q;
  logic [15:0]             shift_q;
  logic [7:0]              tx_q;
  logic                    sclk_prev_q;

  // bus strobes: a transfer completes on the edge where pready is high
  logic acc;
  logic wr_acc;
  logic rd_acc;
  assign acc    = i_psel & i_penable & o_pready;
  assign wr_acc = acc & i_pwrite;
  assign rd_acc = acc & ~i_pwrite;

  logic heat_rise;
  logic open_hit;
  logic short_hit;
  logic fault_clr;
  logic [7:0] fault_byte;
  assign heat_rise = heat_s & ~heat_prev_q;
  // RL18 only lit segments can report
  assign open_hit  = |(seg_q & led_s[15:0]);
  assign short_hit = |(seg_q & led_s[31:16]);
  // RL6 RL7 only writes clear, data ignored
  assign fault_clr = (wr_acc && i_paddr == otf_pkg::ADDR_FAULT) | link_clr_q;
  // RL17 summary is the or of three flags
  assign fault_byte = {open_q | short_q | heat_flag_q, PART_ID, 2'h0,
                       heat_flag_q, short_q, open_q};

  // apb handshake: one wait cycle, read data captured with pready
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && i_penable && !o_pready) begin
        if (i_paddr == otf_pkg::ADDR_CTRL) begin
          o_prdata <= {16'h0000, own_q, phase_q, 2'h0, ripple_q, run_q};
        end else if (i_paddr == otf_pkg::ADDR_FAULT) begin
          o_prdata <= {24'h00_0000, fault_byte};
        end else if (i_paddr == otf_pkg::ADDR_DISP) begin
          o_prdata <= {16'h0000, disp_q};
        end else if (i_paddr == otf_pkg::ADDR_INTENS) begin
          o_prdata <= {24'h00_0000, intens_q};
        end else if (i_paddr == otf_pkg::ADDR_IRQ_STAT) begin
          o_prdata <= {29'h0000_0000, irq_stat_q};
        end else if (i_paddr == otf_pkg::ADDR_IRQ_MASK) begin
          o_prdata <= {29'h0000_0000, irq_mask_q};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // RL9 RL10 control register, defaults under reset
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      run_q    <= otf_pkg::CTRL_RST[otf_pkg::CTRL_RUN];
      ripple_q <= otf_pkg::CTRL_RST[otf_pkg::CTRL_RIPPLE];
      phase_q  <= otf_pkg::CTRL_RST[otf_pkg::CTRL_PHASE_LSB +: 4];
      own_q    <= otf_pkg::CTRL_RST[otf_pkg::CTRL_OWN_LSB +: 8];
    end else begin
      if (wr_acc && i_paddr == otf_pkg::ADDR_CTRL) begin
        ripple_q <= i_pwdata[otf_pkg::CTRL_RIPPLE];
        phase_q  <= i_pwdata[otf_pkg::CTRL_PHASE_LSB +: 4];
        own_q    <= i_pwdata[otf_pkg::CTRL_OWN_LSB +: 8];
        run_q    <= i_pwdata[otf_pkg::CTRL_RUN];
      end
      // RL2 RL3 heat forces shutdown, overrides any set
      if (heat_s) begin
        run_q <= 1'b0;
      end
    end
  end

  // display data and digit intensity, kept through shutdown
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      disp_q   <= 16'h0000;
      intens_q <= 8'h00;
    end else begin
      if (wr_acc && i_paddr == otf_pkg::ADDR_DISP) begin
        disp_q <= i_pwdata[15:0];
      end
      if (wr_acc && i_paddr == otf_pkg::ADDR_INTENS) begin
        intens_q <= i_pwdata[7:0];
      end
    end
  end

  // RL1 RL4 RL5 sticky fault flags, set beats clear
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      open_q      <= 1'b0;
      short_q     <= 1'b0;
      heat_flag_q <= 1'b0;
    end else begin
      open_q      <= open_hit | (open_q & ~fault_clr);
      short_q     <= short_hit | (short_q & ~fault_clr);
      heat_flag_q <= heat_s | (heat_flag_q & ~fault_clr);
    end
  end

  // interrupt status (write one to clear), mask, level output
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      irq_stat_q  <= '0;
      irq_mask_q  <= '0;
      heat_prev_q <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      heat_prev_q <= heat_s;
      if (wr_acc && i_paddr == otf_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= i_pwdata[otf_pkg::IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q
                     & ~((wr_acc && i_paddr == otf_pkg::ADDR_IRQ_STAT)
                         ? i_pwdata[otf_pkg::IRQ_W-1:0] : '0))
                    | {link_clr_q,
                       (open_hit & ~open_q) | (short_hit & ~short_q),
                       heat_rise};
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // RL15 RL16 pwm per digit, phase offset when ripple on
  logic [3:0] pwm_ph;
  logic       dig0_on;
  logic       dig1_on;
  assign pwm_ph  = ripple_q ? 4'(pwm_cnt_q + phase_q) : pwm_cnt_q;
  assign dig0_on = pwm_ph < intens_q[3:0];
  assign dig1_on = pwm_ph < intens_q[7:4];

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pwm_div_q  <= 2'h0;
      pwm_cnt_q  <= 4'h0;
      seg_q      <= 16'h0000;
      o_seg      <= 16'h0000;
      o_shutdown <= 1'b1;
    end else begin
      pwm_div_q <= (pwm_div_q == otf_pkg::PWM_DIV_LAST) ? 2'h0 : 2'(pwm_div_q + 2'h1);
      if (pwm_div_q == otf_pkg::PWM_DIV_LAST) begin
        pwm_cnt_q <= 4'(pwm_cnt_q + 4'h1);
      end
      seg_q      <= run_q ? (disp_q & {{8{dig1_on}}, {8{dig0_on}}}) : 16'h0000;
      o_seg      <= run_q ? (disp_q & {{8{dig1_on}}, {8{dig0_on}}}) : 16'h0000;
      o_shutdown <= ~run_q;
    end
  end

  // serial link: header on sclk rise, read byte out on sclk fall
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      link_st_q      <= otf_pkg::LK_IDLE;
      bit_cnt_q      <= 5'h00;
      shift_q        <= 16'h0000;
      tx_q           <= 8'h00;
      sclk_prev_q    <= 1'b0;
      link_clr_q     <= 1'b0;
      o_link_dout    <= 1'b0;
      o_link_dout_oe <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      link_clr_q  <= 1'b0;
      if (cs_n_s) begin
        // RL8 completed write of the fault code clears every listener
        if (link_st_q == otf_pkg::LK_HDR && bit_cnt_q == otf_pkg::LINK_HDR_BITS
            && !shift_q[15] && shift_q[14:8] == otf_pkg::LINK_FAULT_CODE) begin
          link_clr_q <= 1'b1;
        end
        link_st_q      <= otf_pkg::LK_IDLE;
        o_link_dout_oe <= 1'b0;
      end else begin
        case (link_st_q)
          otf_pkg::LK_IDLE: begin
            link_st_q <= otf_pkg::LK_HDR;
            bit_cnt_q <= 5'h00;
          end
          otf_pkg::LK_HDR: begin
            if (sclk_rise && bit_cnt_q != otf_pkg::LINK_HDR_BITS) begin
              shift_q   <= {shift_q[14:0], din_s};
              bit_cnt_q <= 5'(bit_cnt_q + 5'h01);
              // RL12 eight-bit driver address selects the reader
              if (bit_cnt_q == 5'(otf_pkg::LINK_HDR_BITS - 5'h01) && shift_q[14]
                  && shift_q[13:7] == otf_pkg::LINK_FAULT_CODE
                  && {shift_q[6:0], din_s} == own_q) begin
                link_st_q <= otf_pkg::LK_READ;
                bit_cnt_q <= 5'h00;
                tx_q      <= fault_byte;
              end
            end
          end
          otf_pkg::LK_READ: begin
            // RL14 drive only the addressed read byte
            if (sclk_fall) begin
              if (bit_cnt_q != otf_pkg::LINK_RD_BITS) begin
                o_link_dout    <= tx_q[7];
                o_link_dout_oe <= 1'b1;
                tx_q           <= {tx_q[6:0], 1'b0};
                bit_cnt_q      <= 5'(bit_cnt_q + 5'h01);
              end else begin
                o_link_dout_oe <= 1'b0;
              end
            end
          end
          default: begin
            link_st_q <= otf_pkg::LK_IDLE;
          end
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_fault_write;
    wr_acc && i_paddr == otf_pkg::ADDR_FAULT && !heat_s && !open_hit && !short_hit;
  endsequence

  sequence s_read_entry;
    link_st_q == otf_pkg::LK_HDR ##1 link_st_q == otf_pkg::LK_READ;
  endsequence

  heat_sets_flag_a: assert property (heat_s |=> heat_flag_q) // RL1
    else $error("overheat did not latch flag");

  heat_stops_run_a: assert property ( // RL2
    heat_s |=> !run_q ##1 o_shutdown)
    else $error("overheat did not force shutdown");

  run_blocked_a: assert property (
    wr_acc && i_paddr == otf_pkg::ADDR_CTRL && i_pwdata[0] && heat_s |=> !run_q) // RL3
    else $error("run set accepted while hot");

  flag_sticky_a: assert property (heat_flag_q && !fault_clr |=> heat_flag_q) // RL4
    else $error("overheat flag lost without clear");

  fault_clear_a: assert property ( // RL5
    s_fault_write |=> !open_q && !short_q && !heat_flag_q)
    else $error("fault write did not clear flags");

  read_keeps_a: assert property (
    rd_acc && i_paddr == otf_pkg::ADDR_FAULT && heat_flag_q && !link_clr_q
    |=> heat_flag_q && o_pready == 1'b0) // RL7
    else $error("fault read altered flag");

  link_clear_a: assert property (
    link_clr_q && !heat_s && !open_hit && !short_hit |=> !heat_flag_q && !open_q) // RL8
    else $error("serial fault write did not clear");

  reset_default_a: assert property (
    @(posedge i_mclk) disable iff (1'b0) !i_resetn |=> !run_q && o_seg == 16'h0000) // RL9
    else $error("reset did not restore defaults");

  dout_quiet_a: assert property (s_read_entry |-> !o_link_dout_oe) // RL14
    else $error("output drove before read data");

  oe_read_only_a: assert property (o_link_dout_oe |-> link_st_q == otf_pkg::LK_READ) // RL14
    else $error("output enabled outside a read");

  dim_digit_a: assert property (o_seg[7:0] != 8'h00 |-> $past(intens_q[3:0]) != 4'h0) // RL15
    else $error("digit lit at zero intensity");

  led_gate_a: assert property ($rose(open_q) |-> $past(open_hit)) // RL18
    else $error("open flag set on unlit LED");

endmodule : otf_top

`default_nettype wire

// file: dv/otf_host_model.sv
/*
  Host model on the serial link of one driver: frames with header and read-back.
  Assumes: sclk of 400 ns runs only inside frames; cs_n high between them.
*/
`timescale 1ns/1ps
`default_nettype none

module otf_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din,
  input  wire logic i_dout,
  input  wire logic i_dout_oe
);
  logic last_q;
  logic line;

  // a released line shows the inverse of its last driven level
  always @* line = (i_dout_oe === 1'b1) ? i_dout : ~last_q;
  always @* if (i_dout_oe === 1'b1) last_q = i_dout;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
    last_q = 1'b0;
  end

  task automatic xfer(input logic rw, input logic [6:0] code, input logic [7:0] dat,
                      output logic [7:0] rd);
    logic [15:0] hdr;
    hdr = {rw, code, dat};
    rd  = 8'h00;
    #137 o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_din = hdr[i];
      #200 o_sclk = 1'b1;
      #200 o_sclk = 1'b0;
    end
    if (rw) begin
      for (int i = 7; i >= 0; i--) begin
        #200 o_sclk = 1'b1;
        rd[i] = line; // sampled on the rise
        #200 o_sclk = 1'b0;
      end
    end
    #200 o_cs_n = 1'b1;
    #400;
  endtask : xfer
endmodule : otf_host_model
`default_nettype wire

// file: dv/otf_top_test.sv
/*
  Self-checking bench of the overheat fault block: APB, faults, pwm, link.
  Assumes: the host model drives the link; APB waits are bounded.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module otf_top_test;
  localparam logic [1:0] PRT = 2'h2; // arbitrary value
  logic        mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h82d08f54;
  logic        pready, pslverr, overheat = 1'b0, sclk, cs_n, din, dout, dout_oe, shutdown;
  logic        irq;
  logic [15:0] led_open = 16'h0, led_short = 16'h0, seg;
  logic [33:0] exq[$];
  logic [33:0] ev;
  logic [7:0]  rd;
  int          fail_count = 0, n_checks = 0, oe_cnt = 0, c0, c1, cyc = 0, r0, r1;

  otf_top #(.PART_ID(PRT)) otf_top_inst (.i_mclk(mclk), .i_resetn(resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_overheat(overheat),
    .i_led_open(led_open), .i_led_short(led_short), .i_link_sclk(sclk),
    .i_link_cs_n(cs_n), .i_link_din(din), .o_link_dout(dout), .o_link_dout_oe(dout_oe),
    .o_seg(seg), .o_shutdown(shutdown), .o_irq(irq));
  otf_host_model otf_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .i_dout(dout), .i_dout_oe(dout_oe));

  // clock and serial-drive watch
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (dout_oe === 1'b1) oe_cnt++;
  // free cycle stamp, updated after the edge so readers see a settled value
  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs

  function automatic logic [31:0] flt(input logic o, input logic s, input logic h);
    return {24'h0, o | s | h, PRT, 2'b00, h, s, o};
  endfunction : flt

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick

  // cycle stamp of the next rise of segment 0
  task automatic rise_at(output int t);
    do @(posedge mclk); while (seg[0] !== 1'b0);
    do @(posedge mclk); while (seg[0] !== 1'b1);
    t = cyc;
  endtask : rise_at

  // one APB transfer; expectation noted first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic er);
    int n;
    exq.push_back({~wr, er, wr ? 32'h0 : d});
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // answer watcher takes the oldest note
  always @(posedge mclk) if (pready === 1'b1) begin
    ev = (exq.size() > 0) ? exq.pop_front() : 34'h3_ffff_ffff;
    `CHK("pslverr", ev[32], pslverr)
    if (ev[33]) `CHK("prdata", ev[31:0], prdata)
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    #500000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    tick(5); // reset held
    resetn <= 1'b1;
    `CHK("shutdown", 1'b1, shutdown)
    apb(0, otf_pkg::ADDR_CTRL, 32'h0, 0);
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 0), 0);
    apb(0, 8'h20, 32'h0, 1);
    apb(1, 8'h20, xs(), 1);
    apb(1, otf_pkg::ADDR_CTRL, 32'h0301, 0);
    apb(1, otf_pkg::ADDR_IRQ_MASK, 32'h7, 0);
    led_short <= 16'hffff;
    tick(20);
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 0), 0);
    led_short <= 16'h0;
    apb(1, otf_pkg::ADDR_DISP, 32'hffff, 0);
    apb(1, otf_pkg::ADDR_INTENS, 32'hc4, 0);
    tick(4);
    c0 = 0; c1 = 0;
    repeat (64 * otf_pkg::PWM_DIV) begin
      @(posedge mclk);
      c0 += (seg[0] === 1'b1);
      c1 += (seg[8] === 1'b1);
    end
    `CHK("duty0", 4 * 4 * otf_pkg::PWM_DIV, c0)
    `CHK("duty1", 12 * 4 * otf_pkg::PWM_DIV, c1)
    rise_at(r0);
    apb(1, otf_pkg::ADDR_CTRL, 32'h0383, 0);
    tick(16 * otf_pkg::PWM_DIV);
    rise_at(r1);
    `CHK("ripple_ofs", 8 * otf_pkg::PWM_DIV, (r1 - r0) % (16 * otf_pkg::PWM_DIV))
    apb(1, otf_pkg::ADDR_CTRL, 32'h0301, 0);
    led_open <= 16'h0100;
    led_short <= 16'h0001;
    tick(16 * otf_pkg::PWM_DIV + 4);
    led_open <= 16'h0;
    led_short <= 16'h0;
    apb(0, otf_pkg::ADDR_FAULT, flt(1, 1, 0), 0);
    `CHK("irq", 1'b1, irq)
    apb(1, otf_pkg::ADDR_FAULT, xs(), 0);
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 0), 0);
    apb(1, otf_pkg::ADDR_IRQ_STAT, 32'h7, 0);
    tick(3);
    `CHK("irq", 1'b0, irq)
    overheat <= 1'b1;
    tick(2);
    `CHK("shutdown", 1'b0, shutdown)
    tick(6);
    `CHK("shutdown", 1'b1, shutdown)
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 1), 0);
    apb(0, otf_pkg::ADDR_DISP, 32'hffff, 0);
    apb(0, otf_pkg::ADDR_CTRL, 32'h0300, 0);
    apb(1, otf_pkg::ADDR_CTRL, 32'h0301, 0);
    apb(0, otf_pkg::ADDR_CTRL, 32'h0300, 0);
    `CHK("shutdown", 1'b1, shutdown)
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 1), 0);
    overheat <= 1'b0;
    tick(6);
    apb(1, otf_pkg::ADDR_CTRL, 32'h0301, 0);
    tick(3);
    `CHK("shutdown", 1'b0, shutdown)
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 1), 0);
    otf_host_model_inst.xfer(1'b1, otf_pkg::LINK_FAULT_CODE, 8'h03, rd);
    `CHK("link_rd", flt(0, 0, 1), {24'h0, rd})
    oe_cnt = 0;
    otf_host_model_inst.xfer(1'b1, otf_pkg::LINK_FAULT_CODE, 8'h07, rd);
    `CHK("oe_cnt", 0, oe_cnt)
    otf_host_model_inst.xfer(1'b0, otf_pkg::LINK_FAULT_CODE, 8'(xs()), rd);
    tick(5);
    apb(0, otf_pkg::ADDR_FAULT, flt(0, 0, 0), 0);
    apb(0, otf_pkg::ADDR_IRQ_STAT, 32'h5, 0);
    apb(1, otf_pkg::ADDR_IRQ_MASK, 32'h0, 0);
    tick(3);
    `CHK("irq_masked", 1'b0, irq)
    apb(1, otf_pkg::ADDR_IRQ_STAT, 32'h7, 0);
    @(posedge mclk);
    resetn <= 1'b0;
    tick(5);
    `CHK("shutdown", 1'b1, shutdown)
    resetn <= 1'b1;
    apb(0, otf_pkg::ADDR_CTRL, 32'h0, 0);
    apb(0, otf_pkg::ADDR_IRQ_MASK, 32'h0, 0);
    tick(3);
    tally_and_finish();
  end
endmodule : otf_top_test
`default_nettype wire
